//--- bmr_pkg.sv
// Constants shared by the battery monitor register layer: map, fields, timing.
// Assumes a 100 MHz core clock; the serial line protocol sits outside this block.
package bmr_pkg;
  // ****************************************************************
  // Register and memory map
  // ****************************************************************
  localparam logic [7:0] ADDR_PROT = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h01;
  localparam logic [7:0] ADDR_EECTL = 8'h07;
  localparam logic [7:0] ADDR_SPEC = 8'h08;
  localparam logic [7:0] ADDR_VOLT_HI = 8'h0c;
  localparam logic [7:0] ADDR_VOLT_LO = 8'h0d;
  localparam logic [7:0] ADDR_CURR_HI = 8'h0e;
  localparam logic [7:0] ADDR_CURR_LO = 8'h0f;
  localparam logic [7:0] ADDR_ACC_HI = 8'h10;
  localparam logic [7:0] ADDR_ACC_LO = 8'h11;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h18;
  localparam logic [7:0] ADDR_TEMP_LO = 8'h19;
  localparam logic [7:0] ADDR_EE_FIRST = 8'h20;
  localparam logic [7:0] ADDR_EE_LAST = 8'h3f;
  localparam logic [7:0] ADDR_SRAM_FIRST = 8'h80;
  localparam logic [7:0] ADDR_SRAM_LAST = 8'h8f;
  localparam int EE_BLOCK_BIT = 4;
  localparam logic [4:0] EE_PROT_DEFAULT = 5'h10;
  localparam logic [4:0] EE_STAT_DEFAULT = 5'h11;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int PROT_HIGH_CELL = 7;
  localparam int PROT_LOW_CELL = 6;
  localparam int PROT_CHG_OC = 5;
  localparam int PROT_DIS_OC = 4;
  localparam int PROT_CC_N = 3;
  localparam int PROT_DC_N = 2;
  localparam int PROT_CHG_PERMIT = 1;
  localparam int PROT_DIS_PERMIT = 0;
  localparam int STAT_LSB = 3;
  localparam int STAT_IDLE_SLEEP = 5;
  localparam int EECTL_COPY_BUSY = 7;
  localparam int EECTL_LOCK_EN = 6;
  localparam int SPEC_PS_LATCH = 7;
  localparam int SPEC_PROG_IO = 6;
  localparam int VAL_SHIFT = 5;
  localparam logic signed [15:0] VOLT_LIMIT = 16'sh03ff;
  localparam logic signed [15:0] TEMP_LIMIT = 16'sh03f8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int VOLT_PERIOD_US = 3400;
  localparam int CURR_PERIOD_US = 88000;
  localparam int TEMP_PERIOD_US = 220000;
  localparam int IDLE_LOW_US = 2000000;
  localparam int VOLT_CYC = VOLT_PERIOD_US * CLK_MHZ;
  localparam int CURR_CYC = CURR_PERIOD_US * CLK_MHZ;
  localparam int TEMP_CYC = TEMP_PERIOD_US * CLK_MHZ;
  localparam int IDLE_LOW_CYC = IDLE_LOW_US * CLK_MHZ;
  // ****************************************************************
  // Commands and modes
  // ****************************************************************
  typedef enum logic [2:0] {
    BMR_READ = 3'h0,
    BMR_WRITE = 3'h1,
    BMR_COPY = 3'h2,
    BMR_RECALL = 3'h3,
    BMR_LOCK = 3'h4,
    BMR_END = 3'h5
  } bmr_op_t;
  typedef enum logic {
    BMR_ACTIVE = 1'b0,
    BMR_SLEEP = 1'b1
  } bmr_mode_t;
endpackage

//--- bmr_regs.sv
// Register, shadow memory and control layer of a single-cell battery monitor.
// Assumes a decoded command port from a serial front end and sampled analog results.
`timescale 1ns/1ps
module bmr_regs #(
  parameter int unsigned VOLT_CYCLES = bmr_pkg::VOLT_CYC,
  parameter int unsigned CURR_CYCLES = bmr_pkg::CURR_CYC,
  parameter int unsigned TEMP_CYCLES = bmr_pkg::TEMP_CYC,
  parameter int unsigned IDLE_LOW_CYCLES = bmr_pkg::IDLE_LOW_CYC,
  parameter int unsigned COPY_CYCLES = 100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire bmr_pkg::bmr_op_t cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic signed [15:0] cell_voltage_input,
  input wire logic signed [15:0] temp_sample,
  input wire logic [15:0] current_sample,
  input wire logic cond_high_cell,
  input wire logic cond_low_cell,
  input wire logic cond_chg_oc,
  input wire logic cond_dis_oc,
  input wire logic one_wire_line,
  input wire logic power_switch_sense,
  input wire logic prog_io_in,
  output logic prog_io_out,
  output logic prog_io_oe,
  output logic charge_fet_ctrl_n,
  output logic discharge_fet_ctrl_n,
  output logic sleep_mode
);
  localparam int VW = $clog2(VOLT_CYCLES);
  localparam int CW = $clog2(CURR_CYCLES);
  localparam int TW = $clog2(TEMP_CYCLES);
  localparam int LW = $clog2(IDLE_LOW_CYCLES + 1);
  localparam int KW = $clog2(COPY_CYCLES + 1);

  generate
    if (VOLT_CYCLES < 2 || CURR_CYCLES < 2 || TEMP_CYCLES < 2 || IDLE_LOW_CYCLES < 1
        || COPY_CYCLES < 1)
    begin : g_bad
      $error("bmr_regs: cycle counts too small");
    end
  endgenerate

  // ****************************************************************
  // State
  // ****************************************************************
  // Pin index 0: serial line, 1: power switch sense, 2: prog_io pad
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
    bmr_pkg::bmr_mode_t mode;
    logic [VW-1:0] vcnt;
    logic [CW-1:0] ccnt;
    logic [TW-1:0] tcnt;
    logic [LW-1:0] lcnt;
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] temp;
    logic [15:0] acc;
    logic [3:0] flags;
    logic chg_permit;
    logic dis_permit;
    logic [2:0] stat;
    logic lock_en;
    logic [1:0] locked;
    logic [KW-1:0] busy;
    logic ps_latch;
    logic pio_bit;
    logic [31:0][7:0] shadow;
    logic [31:0][7:0] nvm;
    logic [15:0][7:0] sram;
    logic hold_v;
    logic [7:0] hold_addr;
    logic [7:0] hold_lo;
    logic [7:0] rd_data;
    logic rd_valid;
    logic cc_n;
    logic dc_n;
    logic pio_oe;
  } bmr_state_t;

  bmr_state_t q;
  bmr_state_t n;

  function automatic logic [10:0] bmr_sat(input logic signed [15:0] v,
                                          input logic signed [15:0] lim);
    logic signed [15:0] r;
    r = v;
    if (v > lim)
    begin
      r = lim;
    end
    else if (v < -lim)
    begin
      r = -lim;
    end
    return r[10:0];
  endfunction

  logic line_long;
  logic v_tick;
  logic t_tick;
  logic c_tick;
  logic is_wr;
  logic is_rd;
  logic ee_hit;
  logic ee_blk;
  logic [7:0] rv;

  assign line_long = (q.lcnt == LW'(IDLE_LOW_CYCLES));
  assign v_tick = (q.vcnt == VW'(VOLT_CYCLES - 1));
  assign c_tick = (q.ccnt == CW'(CURR_CYCLES - 1));
  assign t_tick = (q.tcnt == TW'(TEMP_CYCLES - 1));
  assign is_wr = cmd_valid && (cmd_op == bmr_pkg::BMR_WRITE);
  assign is_rd = cmd_valid && (cmd_op == bmr_pkg::BMR_READ);
  assign ee_hit = (cmd_addr >= bmr_pkg::ADDR_EE_FIRST) && (cmd_addr <= bmr_pkg::ADDR_EE_LAST);
  assign ee_blk = cmd_addr[bmr_pkg::EE_BLOCK_BIT];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    n = q;
    rv = bmr_pkg::UNMAPPED_DATA;
    n.rd_valid = 1'b0;
    // Pads are asynchronous: a level counts once stages two and three agree
    n.s1 = {prog_io_in, power_switch_sense, one_wire_line};
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < 3; i++)
    begin
      if (q.s2[i] == q.s3[i])
      begin
        n.filt[i] = q.s3[i];
      end
    end

    // Measurement refresh
    n.vcnt = v_tick ? '0 : q.vcnt + 1'b1;
    n.ccnt = c_tick ? '0 : q.ccnt + 1'b1;
    n.tcnt = t_tick ? '0 : q.tcnt + 1'b1;
    if (v_tick)
    begin
      n.volt = {bmr_sat(cell_voltage_input, bmr_pkg::VOLT_LIMIT), 5'h00};
    end
    if (c_tick)
    begin
      n.curr = current_sample;
    end
    if (t_tick)
    begin
      n.temp = {bmr_sat(temp_sample, bmr_pkg::TEMP_LIMIT), 5'h00};
    end

    // Serial line held low: saturating counter, cleared by any high
    if (q.filt[0])
    begin
      n.lcnt = '0;
    end
    else if (!line_long)
    begin
      n.lcnt = q.lcnt + 1'b1;
    end

    if (q.busy != '0)
    begin
      n.busy = q.busy - 1'b1;
    end

    // Host commands; register writes first so hardware sets below win
    if (is_rd)
    begin
      if (cmd_addr == bmr_pkg::ADDR_PROT)
      begin
        rv = {q.flags, q.cc_n, q.dc_n, q.chg_permit, q.dis_permit};
      end
      else if (cmd_addr == bmr_pkg::ADDR_STAT)
      begin
        rv = {2'b00, q.stat, 3'b000};
      end
      else if (cmd_addr == bmr_pkg::ADDR_EECTL)
      begin
        rv = {(q.busy != '0), q.lock_en, 4'h0, q.locked};
      end
      else if (cmd_addr == bmr_pkg::ADDR_SPEC)
      begin
        rv = {q.ps_latch, q.filt[2], 6'h00};
      end
      else if (q.hold_v && cmd_addr == q.hold_addr + 8'h01)
      begin
        rv = q.hold_lo;
      end
      else if (cmd_addr == bmr_pkg::ADDR_VOLT_HI || cmd_addr == bmr_pkg::ADDR_CURR_HI
               || cmd_addr == bmr_pkg::ADDR_ACC_HI || cmd_addr == bmr_pkg::ADDR_TEMP_HI)
      begin
        // Both bytes captured together so a refresh between them cannot tear
        n.hold_v = 1'b1;
        n.hold_addr = cmd_addr;
        if (cmd_addr == bmr_pkg::ADDR_VOLT_HI)
        begin
          {rv, n.hold_lo} = q.volt;
        end
        else if (cmd_addr == bmr_pkg::ADDR_CURR_HI)
        begin
          {rv, n.hold_lo} = q.curr;
        end
        else if (cmd_addr == bmr_pkg::ADDR_ACC_HI)
        begin
          {rv, n.hold_lo} = q.acc;
        end
        else
        begin
          {rv, n.hold_lo} = q.temp;
        end
      end
      else if (cmd_addr == bmr_pkg::ADDR_VOLT_LO)
      begin
        rv = q.volt[7:0];
      end
      else if (cmd_addr == bmr_pkg::ADDR_CURR_LO)
      begin
        rv = q.curr[7:0];
      end
      else if (cmd_addr == bmr_pkg::ADDR_ACC_LO)
      begin
        rv = q.acc[7:0];
      end
      else if (cmd_addr == bmr_pkg::ADDR_TEMP_LO)
      begin
        rv = q.temp[7:0];
      end
      else if (ee_hit)
      begin
        rv = q.shadow[cmd_addr[4:0]];
      end
      else if (cmd_addr >= bmr_pkg::ADDR_SRAM_FIRST && cmd_addr <= bmr_pkg::ADDR_SRAM_LAST)
      begin
        rv = q.sram[cmd_addr[3:0]];
      end
      n.rd_data = rv;
      n.rd_valid = 1'b1;
    end
    else if (is_wr)
    begin
      if (cmd_addr == bmr_pkg::ADDR_PROT)
      begin
        n.flags = q.flags & cmd_wdata[7:4];
        n.chg_permit = cmd_wdata[bmr_pkg::PROT_CHG_PERMIT];
        n.dis_permit = cmd_wdata[bmr_pkg::PROT_DIS_PERMIT];
      end
      else if (cmd_addr == bmr_pkg::ADDR_EECTL)
      begin
        n.lock_en = cmd_wdata[bmr_pkg::EECTL_LOCK_EN];
      end
      else if (cmd_addr == bmr_pkg::ADDR_SPEC)
      begin
        if (cmd_wdata[bmr_pkg::SPEC_PS_LATCH])
        begin
          n.ps_latch = 1'b1;
        end
        n.pio_bit = cmd_wdata[bmr_pkg::SPEC_PROG_IO];
      end
      else if (cmd_addr == bmr_pkg::ADDR_ACC_HI)
      begin
        n.acc[15:8] = cmd_wdata;
      end
      else if (cmd_addr == bmr_pkg::ADDR_ACC_LO)
      begin
        n.acc[7:0] = cmd_wdata;
      end
      else if (ee_hit)
      begin
        // Locked blocks and an ongoing copy drop the write silently
        if (!q.locked[ee_blk] && q.busy == '0)
        begin
          n.shadow[cmd_addr[4:0]] = cmd_wdata;
        end
      end
      else if (cmd_addr >= bmr_pkg::ADDR_SRAM_FIRST && cmd_addr <= bmr_pkg::ADDR_SRAM_LAST)
      begin
        n.sram[cmd_addr[3:0]] = cmd_wdata;
      end
    end
    else if (cmd_valid && cmd_op == bmr_pkg::BMR_COPY)
    begin
      if (!q.locked[ee_blk] && q.busy == '0)
      begin
        for (int i = 0; i < 16; i++)
        begin
          n.nvm[{ee_blk, 4'(i)}] = q.shadow[{ee_blk, 4'(i)}];
        end
        n.busy = KW'(COPY_CYCLES);
      end
    end
    else if (cmd_valid && cmd_op == bmr_pkg::BMR_RECALL)
    begin
      for (int i = 0; i < 16; i++)
      begin
        n.shadow[{ee_blk, 4'(i)}] = q.nvm[{ee_blk, 4'(i)}];
      end
      if (ee_blk)
      begin
        n.chg_permit = q.nvm[bmr_pkg::EE_PROT_DEFAULT][bmr_pkg::PROT_CHG_PERMIT];
        n.dis_permit = q.nvm[bmr_pkg::EE_PROT_DEFAULT][bmr_pkg::PROT_DIS_PERMIT];
        n.stat = q.nvm[bmr_pkg::EE_STAT_DEFAULT][bmr_pkg::STAT_IDLE_SLEEP:bmr_pkg::STAT_LSB];
      end
    end
    else if (cmd_valid && cmd_op == bmr_pkg::BMR_LOCK)
    begin
      if (q.lock_en)
      begin
        n.locked[ee_blk] = 1'b1;
        n.lock_en = 1'b0;
      end
    end
    else if (cmd_valid && cmd_op == bmr_pkg::BMR_END)
    begin
      n.hold_v = 1'b0;
    end

    // Protection flags: a condition in the clearing cycle keeps the flag
    n.flags = n.flags | {cond_high_cell, cond_low_cell, cond_chg_oc, cond_dis_oc};

    // Sleep and wake
    case (q.mode)
      bmr_pkg::BMR_ACTIVE:
      begin
        if (!q.filt[1])
        begin
          n.ps_latch = 1'b0;
        end
        if (cond_low_cell || (line_long && q.stat[bmr_pkg::STAT_IDLE_SLEEP - bmr_pkg::STAT_LSB]))
        begin
          n.mode = bmr_pkg::BMR_SLEEP;
        end
      end
      default:
      begin
        if (!q.filt[1] || (q.filt[0] && q.stat[bmr_pkg::STAT_IDLE_SLEEP - bmr_pkg::STAT_LSB]))
        begin
          n.mode = bmr_pkg::BMR_ACTIVE;
          n.chg_permit = 1'b1;
          n.dis_permit = 1'b1;
        end
      end
    endcase

    // Sleep or a long low line overrides any host setting of prog_io
    if (n.mode == bmr_pkg::BMR_SLEEP || line_long)
    begin
      n.pio_bit = 1'b1;
    end
    n.pio_oe = !n.pio_bit;

    n.cc_n = cond_high_cell || cond_low_cell || cond_chg_oc || !n.chg_permit
             || (n.mode == bmr_pkg::BMR_SLEEP);
    n.dc_n = cond_low_cell || cond_chg_oc || cond_dis_oc || !n.dis_permit
             || (n.mode == bmr_pkg::BMR_SLEEP);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.s1 <= 3'h7;
      q.s2 <= 3'h7;
      q.s3 <= 3'h7;
      q.filt <= 3'h7;
      q.mode <= bmr_pkg::BMR_ACTIVE;
      q.chg_permit <= 1'b1;
      q.dis_permit <= 1'b1;
      q.ps_latch <= 1'b1;
      q.pio_bit <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  assign rd_data = q.rd_data;
  assign rd_valid = q.rd_valid;
  assign prog_io_out = 1'b0;
  assign prog_io_oe = q.pio_oe;
  assign charge_fet_ctrl_n = q.cc_n;
  assign discharge_fet_ctrl_n = q.dc_n;
  assign sleep_mode = q.mode;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_volt_saturate: assert property (
    v_tick && (cell_voltage_input > 16'sh03ff) |=> q.volt == 16'h7fe0)
    else $error("voltage not saturated");
  chk_temp_steady: assert property (
    !t_tick |=> $stable(q.temp))
    else $error("temperature changed between refreshes");
  chk_pio_drive: assert property (
    is_wr && cmd_addr == 8'h08 && !cmd_wdata[6] && q.mode == bmr_pkg::BMR_ACTIVE
    && !cond_low_cell && !line_long && !(line_long && q.stat[2]) |=> prog_io_oe)
    else $error("prog_io driver not enabled");
  chk_pio_sense: assert property (
    is_rd && cmd_addr == 8'h08 |=> rd_valid && rd_data[6] == $past(q.filt[2]))
    else $error("prog_io read not pin level");
  chk_sleep_pio: assert property (
    q.mode == bmr_pkg::BMR_SLEEP |-> !prog_io_oe && q.pio_bit)
    else $error("prog_io driven in sleep");
  chk_wake_permit: assert property (
    q.mode == bmr_pkg::BMR_SLEEP && !q.filt[1]
    |=> q.mode == bmr_pkg::BMR_ACTIVE && q.chg_permit && q.dis_permit)
    else $error("wake did not restore permits");
  chk_ps_latch: assert property (
    q.mode == bmr_pkg::BMR_ACTIVE && !q.filt[1] |=> !q.ps_latch)
    else $error("power switch low not latched");
  chk_ps_sticky: assert property (
    !q.ps_latch && !(is_wr && cmd_addr == 8'h08 && cmd_wdata[7]) |=> !q.ps_latch)
    else $error("power switch latch released");
  chk_lock_write: assert property (
    is_wr && ee_hit && q.locked[ee_blk] && cmd_valid |=> $stable(q.shadow))
    else $error("locked block written");
  chk_flag_sticky: assert property (
    !(is_wr && cmd_addr == 8'h00) |=> (q.flags & $past(q.flags)) == $past(q.flags))
    else $error("flag lost without host clear");
  chk_chg_force: assert property (
    !n.chg_permit |=> charge_fet_ctrl_n)
    else $error("charge FET on without permit");
  chk_dis_force: assert property (
    !n.dis_permit |=> discharge_fet_ctrl_n)
    else $error("discharge FET on without permit");
  chk_hold_pair: assert property (
    q.hold_v && !cmd_valid |=> q.hold_v && $stable(q.hold_lo))
    else $error("held low byte changed");
endmodule

//--- bmr_host.sv
// Host model: issues decoded register commands one at a time.
// Assumes the bench clock; each command takes two cycles of the port.
`timescale 1ns/1ps
module bmr_host (
  input wire logic clk,
  output logic cmd_valid,
  output bmr_pkg::bmr_op_t cmd_op,
  output logic [7:0] cmd_addr,
  output logic [7:0] cmd_wdata,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  // ****************************************************************
  // Command issue
  // ****************************************************************
  logic [7:0] last;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = bmr_pkg::BMR_END;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    last = 8'h00;
  end
  // Address and write data are scrambled once the strobe drops, so a stale address never helps
  task automatic cmd(input bmr_pkg::bmr_op_t op, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_addr = ~a;
    cmd_wdata = ~d;
    last = rd_valid ? rd_data : 8'hxx;
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the battery monitor register layer.
// Assumes bmr_regs and the host model; timing parameters are shortened.
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // Signals and helpers
  // ****************************************************************
  logic clk, rst_n, line, psw, pio_ext;
  logic signed [15:0] cv, ts;
  logic [3:0] cond;
  logic [15:0] cs;
  logic cmd_valid, rd_valid, pio_in, pio_out, pio_oe, cc_n, dc_n, slp;
  bmr_pkg::bmr_op_t cmd_op;
  logic [7:0] cmd_addr, cmd_wdata, rd_data;
  int miscompares = 0;
  int n_tests = 0;
  logic [23:0] rows [13] = '{24'h11_3c_3c, 24'h10_a5_a5, 24'h80_5a_5a, 24'h8f_c3_c3,
    24'h20_11_11, 24'h3f_22_22, 24'h01_ff_00, 24'h02_ff_00, 24'h40_ff_00, 24'h90_ff_00,
    24'hff_ff_00, 24'h1a_ff_00, 24'h09_ff_00};
  // Open-drain pad: the driver wins, otherwise the outside level
  assign pio_in = pio_oe ? pio_out : pio_ext;
  bmr_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));
  bmr_regs #(.VOLT_CYCLES(20), .CURR_CYCLES(30), .TEMP_CYCLES(40), .IDLE_LOW_CYCLES(50),
    .COPY_CYCLES(5)) dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .cell_voltage_input(cv), .temp_sample(ts), .current_sample(cs),
    .cond_high_cell(cond[3]), .cond_low_cell(cond[2]), .cond_chg_oc(cond[1]),
    .cond_dis_oc(cond[0]), .one_wire_line(line), .power_switch_sense(psw),
    .prog_io_in(pio_in), .prog_io_out(pio_out), .prog_io_oe(pio_oe),
    .charge_fet_ctrl_n(cc_n), .discharge_fet_ctrl_n(dc_n), .sleep_mode(slp));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.cmd(bmr_pkg::BMR_WRITE, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.cmd(bmr_pkg::BMR_READ, a, 8'h00);
    check($sformatf("addr %h", a), host.last, e);
  endtask
  task automatic op(input bmr_pkg::bmr_op_t o, input logic [7:0] a);
    host.cmd(o, a, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    miscompares++;
    end_of_test();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    rst_n = 1'b0;
    line = 1'b1;
    psw = 1'b1;
    pio_ext = 1'b1;
    cv = 16'sd100;
    ts = -16'sd40;
    cond = 4'h0;
    cs = 16'h1234;
    cy(2);
    rst_n = 1'b1;
    rdc(8'h00, 8'h03);
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
      op(bmr_pkg::BMR_END, 8'h00);
    end
    cy(30);
    rdc(8'h0c, 8'h0c);
    cv = 16'sd2000;
    cy(30);
    rdc(8'h0d, 8'h80);
    op(bmr_pkg::BMR_END, 8'h00);
    rdc(8'h0c, 8'h7f);
    rdc(8'h0d, 8'he0);
    rdc(8'h18, 8'hfb);
    ts = 16'sd2000;
    op(bmr_pkg::BMR_END, 8'h00);
    cy(50);
    rdc(8'h18, 8'h7f);
    op(bmr_pkg::BMR_END, 8'h00);
    rdc(8'h0e, 8'h12);
    cs = 16'hbeef;
    cy(40);
    rdc(8'h0f, 8'h34);
    op(bmr_pkg::BMR_END, 8'h00);
    rdc(8'h0e, 8'hbe);
    rdc(8'h0f, 8'hef);
    op(bmr_pkg::BMR_END, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2)
        continue;
      cond[i] = 1'b1;
      cy(3);
      check("cc_n", {7'h0, cc_n}, {7'h0, i != 0});
      check("dc_n", {7'h0, dc_n}, {7'h0, i != 3});
      cond[i] = 1'b0;
      cy(3);
      rdc(8'h00, 8'h03 | (8'h10 << i));
      wr(8'h00, 8'hf3);
      rdc(8'h00, 8'h03 | (8'h10 << i));
      wr(8'h00, 8'h03);
      rdc(8'h00, 8'h03);
    end
    wr(8'h00, 8'h02);
    rdc(8'h00, 8'h06);
    wr(8'h00, 8'h01);
    rdc(8'h00, 8'h09);
    wr(8'h00, 8'h03);
    wr(8'h08, 8'hc0);
    wr(8'h08, 8'h80);
    check("oe", {7'h0, pio_oe}, 8'h01);
    cy(6);
    rdc(8'h08, 8'h80);
    wr(8'h08, 8'hc0);
    cy(6);
    rdc(8'h08, 8'hc0);
    pio_ext = 1'b0;
    cy(6);
    rdc(8'h08, 8'h80);
    pio_ext = 1'b1;
    psw = 1'b0;
    cy(8);
    psw = 1'b1;
    cy(6);
    check("sleep", {7'h0, slp}, 8'h00);
    rdc(8'h08, 8'h40);
    cy(20);
    rdc(8'h08, 8'h40);
    wr(8'h08, 8'hc0);
    rdc(8'h08, 8'hc0);
    wr(8'h08, 8'h80);
    line = 1'b0;
    cy(60);
    check("oe", {7'h0, pio_oe}, 8'h00);
    check("sleep", {7'h0, slp}, 8'h00);
    line = 1'b1;
    cy(6);
    wr(8'h08, 8'h80);
    wr(8'h00, 8'h00);
    cond[2] = 1'b1;
    cy(3);
    cond[2] = 1'b0;
    check("sleep", {7'h0, slp}, 8'h01);
    check("fets", {6'h0, cc_n, dc_n}, 8'h03);
    check("oe", {7'h0, pio_oe}, 8'h00);
    psw = 1'b0;
    cy(8);
    psw = 1'b1;
    check("sleep", {7'h0, slp}, 8'h00);
    check("dc_n", {7'h0, dc_n}, 8'h00);
    rdc(8'h00, 8'h43);
    wr(8'h00, 8'h03);
    wr(8'h30, 8'h02);
    wr(8'h31, 8'h28);
    op(bmr_pkg::BMR_COPY, 8'h30);
    wr(8'h30, 8'hff);
    rdc(8'h30, 8'h02);
    cy(10);
    wr(8'h30, 8'hff);
    rdc(8'h30, 8'hff);
    op(bmr_pkg::BMR_RECALL, 8'h30);
    rdc(8'h30, 8'h02);
    rdc(8'h00, 8'h06);
    rdc(8'h01, 8'h28);
    wr(8'h00, 8'h03);
    op(bmr_pkg::BMR_LOCK, 8'h20);
    wr(8'h20, 8'h44);
    rdc(8'h20, 8'h44);
    wr(8'h07, 8'h40);
    rdc(8'h07, 8'h40);
    op(bmr_pkg::BMR_LOCK, 8'h20);
    rdc(8'h07, 8'h01);
    wr(8'h20, 8'h55);
    rdc(8'h20, 8'h44);
    op(bmr_pkg::BMR_COPY, 8'h20);
    cy(10);
    op(bmr_pkg::BMR_RECALL, 8'h20);
    rdc(8'h20, 8'h00);
    // Status bit 5 is now set: a long low line sends the block to sleep
    wr(8'h00, 8'h00);
    line = 1'b0;
    cy(60);
    check("sleep", {7'h0, slp}, 8'h01);
    check("oe", {7'h0, pio_oe}, 8'h00);
    line = 1'b1;
    cy(6);
    check("sleep", {7'h0, slp}, 8'h00);
    rdc(8'h00, 8'h03);
    rst_n = 1'b0;
    cy(2);
    check("rd_valid", {7'h0, rd_valid}, 8'h00);
    check("oe", {7'h0, pio_oe}, 8'h00);
    rst_n = 1'b1;
    rdc(8'h30, 8'h00);
    rdc(8'h07, 8'h00);
    rdc(8'h00, 8'h03);
    end_of_test();
  end
endmodule
